// *** rtl/sbc_sideband.sv ***
// sideband pin logic of the processor bus interface with apb control
//
// Summary of operation
// - lane strobes meaningful for 16-bit port accesses
// - upper strobe msb byte, lower strobe lsb
// - masking keeps both strobes inactive on reads
// - strobe pins are strap inputs during reset
// - final-beat flag after next-to-last capture/acknowledge
// - timer expiry output low at terminal count
// - expiry low 1.5 system clocks or held
// - bus fault sampled only in transfers, terminates
// - faulted read raises bus error exception
// - synced interrupts pass internal synchroniser
// - direct interrupts one cycle faster
// - interrupt pins strap address-display and byte order
// - straps taken in final reset cycle
// - strap pins revert to normal after reset
// - clock input double rate, drives all timing
// - float request tri-states every pin output
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "sbc_cfg.svh"
module sbc_sideband import sbc_pkg::*; #(
  parameter int TIMER_W = 16  // timer width
) (
  input  wire logic               CLK,                  // double rate clock in
  input  wire logic               RESETN,               // async reset, low
  input  wire logic               PSEL,                 // apb select
  input  wire logic               PENABLE,              // apb enable
  input  wire logic               PWRITE,               // apb direction
  input  wire logic [7:0]         PADDR,                // apb byte address
  input  wire logic [31:0]        PWDATA,               // apb write data
  output logic      [31:0]        PRDATA,               // apb read data
  output logic                    PREADY,               // apb ready
  output logic                    PSLVERR,              // apb error
  input  wire logic               XFER_RD,              // core read strobe
  input  wire logic               XFER_WR,              // core write strobe
  input  wire logic               XFER_PORT16,          // target is 16-bit port
  input  wire logic [1:0]         XFER_LANES,           // lanes used, bit1 msb
  input  wire logic [1:0]         XFER_BEATS,           // data beats minus one
  input  wire logic               CORE_BUS_GRANT,       // grant from arbiter
  input  wire logic               READ_CAPTURE_ENABLE_N, // pin, read data valid
  input  wire logic               ACK_N,                // pin, datum processed
  input  wire logic               BUS_FAULT_IN_N,       // pin, bus fault
  input  wire logic [2:0]         SYNCED_IRQ_IN_N,      // pin, async irqs
  input  wire logic [2:0]         DIRECT_IRQ_IN_N,      // pin, pre-synced irqs 5:3
  input  wire logic               FLOAT_ALL_REQUEST,    // pin, test float
  input  wire logic [1:0]         NARROW_PORT_LANE_STROBES_N_I,  // lane pin in
  output logic      [1:0]         NARROW_PORT_LANE_STROBES_N_O,  // lane pin out
  output logic                    NARROW_PORT_LANE_STROBES_OE,   // lane pin drive
  output logic                    LAST_BEAT_N_O,        // final beat flag
  output logic                    LAST_BEAT_OE,         // final beat drive
  output logic                    TIMER_EXPIRY_OUT_N_O, // timer expiry
  output logic                    TIMER_EXPIRY_OUT_OE,  // timer expiry drive
  output logic                    SYSTEM_REFERENCE_CLOCK_O,  // half rate clock
  output logic                    SYSTEM_REFERENCE_CLOCK_OE, // clock drive
  output logic                    BUS_GRANT_OUT_N_O,    // grant pin
  output logic                    BUS_GRANT_OUT_OE,     // grant drive
  output logic                    XFER_TERMINATE,       // pulse, end transfer
  output logic                    BUS_ERR_EXC,          // pulse, read fault
  output logic [5:0]              IRQ_PENDING,          // active high irqs
  output logic                    CFG_ADDR_DISPLAY_FORCE_MISS, // strap
  output logic                    CFG_BYTE_ORDER_BIG,   // strap
  output logic [1:0]              CFG_RESERVED_TIE_HIGH // straps
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sirq_s;        // synced irq pins
  logic [3:0] misc_s;        // capture, ack, fault, float
  logic [1:0] lane_s;        // lane pins as straps
  logic       dstrap_s;      // direct irq 3 as strap
  logic       rce_s;         // capture enable, low
  logic       ack_s;         // acknowledge, low
  logic       fault_s;       // bus fault, low
  logic       float_s;       // float request

  // synced irq inputs
  sbc_sync2 #(.W(3)) u_sync_irq (.clk(CLK), .din(SYNCED_IRQ_IN_N), .dout(sirq_s));
  sbc_sync2 #(.W(4)) u_sync_misc (
    .clk(CLK),
    .din({FLOAT_ALL_REQUEST, BUS_FAULT_IN_N, ACK_N, READ_CAPTURE_ENABLE_N}),
    .dout(misc_s)
  );
  sbc_sync2 #(.W(3)) u_sync_strap (
    .clk(CLK),
    .din({DIRECT_IRQ_IN_N[0], NARROW_PORT_LANE_STROBES_N_I}),
    .dout({dstrap_s, lane_s})
  );
  assign rce_s   = misc_s[0];
  assign ack_s   = misc_s[1];
  assign fault_s = misc_s[2];
  assign float_s = misc_s[3];

  ////////////////////////////////////////////////////////////////////////////
  // reset tracking and strap capture
  logic rst_p1_q;  // reset seen, stage 1
  logic rst_p2_q;  // reset window, spans sync delay
  logic [3:0] cfg_q;   // captured straps

  // window stays open two edges past release
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_p1_q <= 1'b1;
      rst_p2_q <= 1'b1;
    end else begin
      rst_p1_q <= 1'b0;
      rst_p2_q <= rst_p1_q;
    end
  end

  // straps follow pins until window closes, then hold
  always_ff @(posedge CLK) begin
    if (rst_p2_q) begin
      cfg_q <= {~lane_s, ~dstrap_s, ~sirq_s[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  logic [2:0]         ctrl_q;      // mask, hold, enable
  logic [TIMER_W-1:0] reload_q;    // timer reload
  logic [TIMER_W-1:0] cnt_q;       // timer count
  logic               fault_st_q;  // sticky fault seen
  logic               held_q;      // held expiry state
  logic               ph_q;        // system clock phase
  wire                setup   = PSEL & ~PENABLE;                  // setup phase
  wire                wr_acc  = PSEL & PENABLE & PWRITE & PREADY; // write commit
  wire                sel_ctl = (PADDR == `SBC_OFS_CTRL);
  wire                sel_rld = (PADDR == `SBC_OFS_RELOAD);
  wire                sel_rst = (PADDR == `SBC_OFS_RESTART);
  wire                sel_st  = (PADDR == `SBC_OFS_STATUS);
  wire                sel_cnt = (PADDR == `SBC_OFS_COUNT);
  wire                mapped  = sel_ctl | sel_rld | sel_rst | sel_st | sel_cnt;
  wire                restart = wr_acc & sel_rst & PWDATA[0];     // timer restart
  wire                clr_flt = wr_acc & sel_st & PWDATA[`SBC_ST_FAULT];
  wire [5:0]          st_word = {held_q, cfg_q[3:2], cfg_q[0], cfg_q[1], fault_st_q};
  wire [31:0]         rd_mux  = sel_ctl ? {29'h0, ctrl_q} :
                                sel_rld ? {{(32-TIMER_W){1'b0}}, reload_q} :
                                sel_st  ? {26'h0, st_word} :
                                sel_cnt ? {{(32-TIMER_W){1'b0}}, cnt_q} : 32'h0;

  // answer in first access cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~mapped;
      if (setup) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // control and reload writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q   <= `SBC_CTRL_RST;
      reload_q <= '1;
    end else if (wr_acc) begin
      if (sel_ctl) ctrl_q <= PWDATA[2:0];
      if (sel_rld) reload_q <= PWDATA[TIMER_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system reference clock, half of the double rate input
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) ph_q <= 1'b0;
    else         ph_q <= ~ph_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer
  localparam int PULSE_N = `SBC_TC_LOW_CYCLES;  // 1.5 system clocks
  logic [1:0] pulse_q;                          // pulse cycles left
  wire        tick   = ph_q & ctrl_q[`SBC_CTRL_TEN];        // system clock tick
  wire        expire = tick & (cnt_q == '0) & ~restart;     // terminal count
  wire        hold   = ctrl_q[`SBC_CTRL_HOLD];
  wire        tc_low = hold ? held_q : (pulse_q != 2'h0);

  // count down, reload on expiry or restart
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= '1;
    end else if (restart | expire) begin
      cnt_q <= reload_q;
    end else if (tick) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // expiry shaping, restart suppresses a coinciding expiry
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pulse_q <= 2'h0;
      held_q  <= 1'b0;
    end else begin
      if (expire)                pulse_q <= 2'(PULSE_N);
      else if (pulse_q != 2'h0)  pulse_q <= pulse_q - 2'h1;
      if (expire & hold)         held_q <= 1'b1;
      else if (restart | ~hold)  held_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer tracking and final beat flag
  sbc_xfer_t  xf_q;       // transfer state
  logic [1:0] left_q;     // beats before final
  logic       strb_q;     // previous strobe level
  wire        active = XFER_RD | XFER_WR;
  wire        strb   = XFER_RD ? ~rce_s : ~ack_s;   // datum strobe
  wire        beat   = strb & ~strb_q;              // one per datum
  logic       final_d;                              // flag next value

  // count datums, flag after next-to-last
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      xf_q   <= XF_IDLE;
      left_q <= 2'h0;
      strb_q <= 1'b0;
    end else begin
      strb_q <= strb & active;
      case (xf_q)
        XF_IDLE: begin
          if (active) begin
            left_q <= XFER_BEATS;
            xf_q   <= (XFER_BEATS == 2'h0) ? XF_FINAL : XF_RUN;
          end
        end
        XF_RUN: begin
          if (!active) xf_q <= XF_IDLE;
          else if (beat) begin
            left_q <= left_q - 2'h1;
            if (left_q == 2'h1) xf_q <= XF_FINAL;
          end
        end
        XF_FINAL: begin
          if (!active) xf_q <= XF_IDLE;
        end
        default: xf_q <= XF_IDLE;
      endcase
    end
  end
  assign final_d = active & (xf_q == XF_FINAL);

  ////////////////////////////////////////////////////////////////////////////
  // bus fault handling, only inside transfers
  wire fault_hit = ~fault_s & active;

  // fault sticky, set wins over clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN)        fault_st_q <= 1'b0;
    else if (fault_hit) fault_st_q <= 1'b1;
    else if (clr_flt)   fault_st_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane strobes: 16-bit ports only, masked reads
  wire       mask_rd = ctrl_q[`SBC_CTRL_MASK_RD] & XFER_RD;
  wire [1:0] lane_d  = (XFER_PORT16 & active & ~mask_rd) ? ~XFER_LANES : 2'h3;
  wire       drive   = ~rst_p2_q & ~float_s;
  logic [2:0] dirq_q;                               // direct irq stage

  // pin and core output flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      NARROW_PORT_LANE_STROBES_N_O <= 2'h3;
      NARROW_PORT_LANE_STROBES_OE  <= 1'b0;          // input during reset
      LAST_BEAT_N_O                <= 1'b1;
      LAST_BEAT_OE                 <= 1'b0;
      TIMER_EXPIRY_OUT_N_O         <= 1'b1;
      TIMER_EXPIRY_OUT_OE          <= 1'b0;
      SYSTEM_REFERENCE_CLOCK_O     <= 1'b0;
      SYSTEM_REFERENCE_CLOCK_OE    <= 1'b0;
      BUS_GRANT_OUT_N_O            <= 1'b1;
      BUS_GRANT_OUT_OE             <= 1'b0;
      XFER_TERMINATE               <= 1'b0;
      BUS_ERR_EXC                  <= 1'b0;
      dirq_q                       <= 3'h0;
      IRQ_PENDING                  <= 6'h0;
    end else begin
      NARROW_PORT_LANE_STROBES_N_O <= lane_d;
      NARROW_PORT_LANE_STROBES_OE  <= drive;
      LAST_BEAT_N_O                <= ~final_d;
      LAST_BEAT_OE                 <= drive;
      TIMER_EXPIRY_OUT_N_O         <= ~tc_low;
      TIMER_EXPIRY_OUT_OE          <= drive;
      SYSTEM_REFERENCE_CLOCK_O     <= ph_q;
      SYSTEM_REFERENCE_CLOCK_OE    <= drive;
      BUS_GRANT_OUT_N_O            <= ~CORE_BUS_GRANT;
      BUS_GRANT_OUT_OE             <= drive;
      XFER_TERMINATE               <= fault_hit;
      BUS_ERR_EXC                  <= fault_hit & XFER_RD;
      dirq_q                       <= ~DIRECT_IRQ_IN_N;   // one stage
      IRQ_PENDING                  <= {dirq_q, ~sirq_s};
    end
  end

  // strap outputs
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CFG_ADDR_DISPLAY_FORCE_MISS <= 1'b0;
      CFG_BYTE_ORDER_BIG          <= 1'b0;
      CFG_RESERVED_TIE_HIGH       <= 2'h0;
    end else begin
      CFG_ADDR_DISPLAY_FORCE_MISS <= cfg_q[1];
      CFG_BYTE_ORDER_BIG          <= cfg_q[0];
      CFG_RESERVED_TIE_HIGH       <= cfg_q[3:2];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_lane_read_mask: assert property (@(posedge CLK) disable iff (!RESETN)
    (ctrl_q[`SBC_CTRL_MASK_RD] && XFER_RD) |=> NARROW_PORT_LANE_STROBES_N_O == 2'h3)
    else $error("lane strobe active on masked read");
  a_lane_strap_in: assert property (@(posedge CLK) disable iff (!RESETN)
    rst_p1_q |=> !NARROW_PORT_LANE_STROBES_OE)
    else $error("lane pin driven in reset window");
  a_last_beat_clear: assert property (@(posedge CLK) disable iff (!RESETN)
    !active |=> LAST_BEAT_N_O)
    else $error("final beat flag outside transfer");
  a_expiry_pulse_len: assert property (@(posedge CLK) disable iff (!RESETN)
    (expire && !hold && pulse_q == 2'h0) ##1 !hold [*3] |->
      !$past(TIMER_EXPIRY_OUT_N_O) && !TIMER_EXPIRY_OUT_N_O ##1 !TIMER_EXPIRY_OUT_N_O)
    else $error("expiry pulse not three clocks");
  a_expiry_release: assert property (@(posedge CLK) disable iff (!RESETN)
    (restart && hold && !expire) ##1 (hold && !expire) |=> TIMER_EXPIRY_OUT_N_O)
    else $error("held expiry not released");
  a_fault_window: assert property (@(posedge CLK) disable iff (!RESETN)
    !active |=> !XFER_TERMINATE && !BUS_ERR_EXC)
    else $error("fault acted outside transfer");
  a_fault_exception: assert property (@(posedge CLK) disable iff (!RESETN)
    (!fault_s && XFER_RD) |=> BUS_ERR_EXC && XFER_TERMINATE)
    else $error("read fault without exception");
  a_irq_latency: assert property (@(posedge CLK) disable iff (!RESETN)
    !rst_p2_q |-> IRQ_PENDING[5:3] == ~$past(DIRECT_IRQ_IN_N, 2)
      && IRQ_PENDING[2:0] == ~$past(SYNCED_IRQ_IN_N, 3))
    else $error("irq latency wrong");
  a_strap_stable: assert property (@(posedge CLK) disable iff (!RESETN)
    !rst_p2_q |=> $stable(cfg_q))
    else $error("straps changed after reset");
  a_float_all: assert property (@(posedge CLK) disable iff (!RESETN)
    float_s |=> !SYSTEM_REFERENCE_CLOCK_OE && !TIMER_EXPIRY_OUT_OE && !BUS_GRANT_OUT_OE
      && !LAST_BEAT_OE && !NARROW_PORT_LANE_STROBES_OE)
    else $error("output driven under float");
  a_refclk_div: assert property (@(posedge CLK) disable iff (!RESETN)
    !rst_p1_q |=> SYSTEM_REFERENCE_CLOCK_O != $past(SYSTEM_REFERENCE_CLOCK_O))
    else $error("reference clock not half rate");
endmodule

// *** shared/sbc_cfg.svh ***
// register offsets, field positions, reset values and timing counts of the sideband block
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH
`define SBC_OFS_CTRL        8'h00
`define SBC_OFS_RELOAD      8'h04
`define SBC_OFS_RESTART     8'h08
`define SBC_OFS_STATUS      8'h0C
`define SBC_OFS_COUNT       8'h10
`define SBC_CTRL_MASK_RD    0
`define SBC_CTRL_HOLD       1
`define SBC_CTRL_TEN        2
`define SBC_ST_FAULT        0
`define SBC_ST_ADDR_DISP    1
`define SBC_ST_BIG          2
`define SBC_ST_RSV_LO       3
`define SBC_ST_RSV_HI       4
`define SBC_ST_EXPIRED      5
`define SBC_CTRL_RST        3'h0
`define SBC_CLK_HZ          50000000
`define SBC_CLK_PER_SYS     2
`define SBC_TC_LOW_HALVES   3
`define SBC_TC_LOW_CYCLES   ((`SBC_TC_LOW_HALVES * `SBC_CLK_PER_SYS) / 2)
`endif

// *** shared/sbc_pkg.sv ***
// types shared by the sideband block
package sbc_pkg;
  typedef enum logic [1:0] {XF_IDLE, XF_RUN, XF_FINAL} sbc_xfer_t;  // transfer tracking
  typedef logic [31:0] sbc_word_t;                                 // bus word
endpackage

// *** rtl/sbc_sync2.sv ***
// two-flop synchroniser for pin inputs, no reset so straps survive reset
`timescale 1ns/1ps
module sbc_sync2 #(
  parameter int W = 1  // number of bits
) (
  input  wire logic         clk,    // clock
  input  wire logic [W-1:0] din,    // asynchronous input
  output logic      [W-1:0] dout    // synchronised output
);
  logic [W-1:0] meta_q;  // first stage, read by second stage only

  // per-bit double flop
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      meta_q[i] <= din[i];
      dout[i]   <= meta_q[i];
    end
  end
endmodule

// *** sim/sbc_mem_model.sv ***
// partner model: memory system answering each beat with capture or acknowledge
`timescale 1ns/1ps
module sbc_mem_model import sbc_pkg::*; (
  input  wire logic       clk,       // clock
  input  wire logic       rd,        // read strobe
  input  wire logic       wr,        // write strobe
  input  wire logic [1:0] beats,     // beats minus one
  input  wire logic [3:0] gap,       // idle cycles before each beat
  output logic            capture_n, // read data valid, low
  output logic            ack_n      // datum processed, low
);
  int i; // beat index
  ////////////////////////////////////////////////////////////
  // idle level at time zero
  initial begin
    capture_n = 1'b1;
    ack_n = 1'b1;
  end
  // one low pulse per beat, prompt or slow by gap
  always begin
    @(posedge clk iff (rd || wr));
    for (i = 0; i <= int'(beats); i++) begin
      repeat (gap) @(posedge clk);
      if (rd) capture_n <= 1'b0;
      else ack_n <= 1'b0;
      @(posedge clk);
      capture_n <= 1'b1;
      ack_n <= 1'b1;
    end
    @(posedge clk iff !(rd || wr)); // wait for strobe release
  end
endmodule

// *** sim/testbench.sv ***
// self-checking bench of the sideband block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench import sbc_pkg::*; ;
  logic clk, rstn, psel, pen, pwr, rd, wr, p16, gnt, flt, fault_n, pready, pslverr, cap_n, ack_n;
  logic [7:0]  paddr;      // apb address
  sbc_word_t   pwdata, prdata, rdat; // apb data
  logic [1:0]  lanes, beats, lso, lsi, rsv; // lane and strap values
  logic [2:0]  sirq, dirq; // interrupt pins
  logic [3:0]  gap;        // partner delay
  logic [5:0]  irq;        // pending irqs
  logic        lso_oe, lb, lb_oe, tx, tx_oe, sc, sc_oe, bg, bg_oe, term, exc, adf, big, e;
  int          errors = 0, compares = 0, n;
  ////////////////////////////////////////////////////////////
  sbc_sideband dut_u (.CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .XFER_RD(rd), .XFER_WR(wr), .XFER_PORT16(p16), .XFER_LANES(lanes), .XFER_BEATS(beats),
    .CORE_BUS_GRANT(gnt), .READ_CAPTURE_ENABLE_N(cap_n), .ACK_N(ack_n), .BUS_FAULT_IN_N(fault_n),
    .SYNCED_IRQ_IN_N(sirq), .DIRECT_IRQ_IN_N(dirq), .FLOAT_ALL_REQUEST(flt),
    .NARROW_PORT_LANE_STROBES_N_I(lsi), .NARROW_PORT_LANE_STROBES_N_O(lso),
    .NARROW_PORT_LANE_STROBES_OE(lso_oe), .LAST_BEAT_N_O(lb), .LAST_BEAT_OE(lb_oe),
    .TIMER_EXPIRY_OUT_N_O(tx), .TIMER_EXPIRY_OUT_OE(tx_oe), .SYSTEM_REFERENCE_CLOCK_O(sc),
    .SYSTEM_REFERENCE_CLOCK_OE(sc_oe), .BUS_GRANT_OUT_N_O(bg), .BUS_GRANT_OUT_OE(bg_oe),
    .XFER_TERMINATE(term), .BUS_ERR_EXC(exc), .IRQ_PENDING(irq),
    .CFG_ADDR_DISPLAY_FORCE_MISS(adf), .CFG_BYTE_ORDER_BIG(big), .CFG_RESERVED_TIE_HIGH(rsv));
  sbc_mem_model mem_u (.clk(clk), .rd(rd), .wr(wr), .beats(beats), .gap(gap),
    .capture_n(cap_n), .ack_n(ack_n));
  ////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 clk = ~clk;
  // verdict and end of run
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // n edges, then let updates settle
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input sbc_word_t d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    rdat = prdata; e = pslverr;
    if (n >= 20) begin errors++; end_sim(); end
    psel <= 1'b0; pen <= 1'b0;
  endtask
  // wait until a signal reaches a level, bounded
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin tick(1); n++; end
    if (n >= lim) begin errors++; end_sim(); end
  endtask
  // main sequence
  initial begin
    clk = 0; rstn = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; rd = 0; wr = 0;
    p16 = 0; lanes = 0; beats = 0; gnt = 0; flt = 0; fault_n = 1; gap = 2;
    lsi = 2'b10; dirq = 3'b110; sirq = 3'b111;
    tick(3);
    rstn <= 1'b1;
    tick(4);
    lsi <= 2'b11; dirq <= 3'b111; sirq <= 3'b110;
    tick(6);
    `CHK("straps", 4'b1001, {adf, big, rsv})
    `CHK("sync irq0", 1'b1, irq[0])
    apb(1'b0, 8'h0C, 0);
    `CHK("status straps", 2'b01, rdat[2:1])
    sirq <= 3'b111;
    apb(1'b0, 8'h00, 0);
    `CHK("ctrl reset", 32'h0, rdat)
    apb(1'b0, 8'h04, 0);
    `CHK("reload reset", 32'h0000FFFF, rdat)
    apb(1'b0, 8'h14, 0);
    `CHK("unmapped err", 1'b1, e)
    $display("test reset and registers done");
    // direct irq one cycle faster than synced
    @(posedge clk);
    dirq <= 3'b101; sirq <= 3'b101;
    tick(2);
    `CHK("irq at 2", 2'b10, {irq[4], irq[1]})
    tick(1);
    `CHK("irq at 3", 2'b11, {irq[4], irq[1]})
    dirq <= 3'b111; sirq <= 3'b111;
    $display("test interrupts done");
    // lane strobes: write, unmasked read, masked read
    p16 <= 1'b1; lanes <= 2'b10; wr <= 1'b1;
    tick(3);
    `CHK("lanes wr", 3'b101, {lso_oe, lso})
    wr <= 1'b0; lanes <= 2'b01; rd <= 1'b1;
    tick(3);
    `CHK("lanes rd", 2'b10, lso)
    rd <= 1'b0;
    apb(1'b1, 8'h00, 32'h1);
    rd <= 1'b1;
    tick(3);
    `CHK("lanes masked", 2'b11, lso)
    rd <= 1'b0; p16 <= 1'b0;
    tick(8);
    apb(1'b1, 8'h00, 32'h0);
    $display("test lanes done");
    // final beat: two-beat read, then single-beat write
    beats <= 2'd1; gap <= 4'd3; rd <= 1'b1;
    tick(3);
    `CHK("last early", 1'b1, lb)
    wait_lvl(lb, 1'b0, 30);
    `CHK("last set", 1'b0, lb)
    tick(2);
    rd <= 1'b0;
    tick(2);
    `CHK("last clear", 1'b1, lb)
    tick(6);
    beats <= 2'd0; wr <= 1'b1;
    tick(2);
    `CHK("last one beat", 1'b0, lb)
    wr <= 1'b0;
    tick(8);
    $display("test final beat done");
    // bus fault: outside transfer, in write, in read
    fault_n <= 1'b0;
    tick(6);
    `CHK("fault idle", 1'b0, term)
    wr <= 1'b1;
    wait_lvl(term, 1'b1, 8);
    `CHK("fault wr exc", 1'b0, exc)
    wr <= 1'b0;
    tick(6);
    rd <= 1'b1;
    wait_lvl(term, 1'b1, 8);
    `CHK("fault rd exc", 1'b1, exc)
    rd <= 1'b0; fault_n <= 1'b1;
    tick(8);
    apb(1'b0, 8'h0C, 0);
    `CHK("fault sticky", 1'b1, rdat[0])
    $display("test bus fault done");
    // timer: pulse mode then held mode
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h00, 32'h4);
    wait_lvl(tx, 1'b0, 40);
    n = 0;
    while (tx === 1'b0 && n < 10) begin tick(1); n++; end
    `CHK("pulse cycles", 3, n)
    apb(1'b1, 8'h00, 32'h6);
    wait_lvl(tx, 1'b0, 40);
    tick(12);
    `CHK("held low", 1'b0, tx)
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    `CHK("held release", 1'b1, tx)
    $display("test timer done");
    // reference clock, grant, then float all pin drivers
    tick(1);
    e = sc;
    `CHK("system_reference_clock drive", 1'b1, sc_oe)
    tick(1);
    `CHK("system_reference_clock toggle", ~e, sc)
    gnt <= 1'b1;
    tick(3);
    `CHK("grant", 2'b10, {bg_oe, bg})
    flt <= 1'b1;
    tick(4);
    `CHK("float", 5'b0, {lso_oe, lb_oe, tx_oe, sc_oe, bg_oe})
    $display("test float done");
    end_sim();
  end
endmodule
